// [rtl/isp_boot_pkg.sv]
package isbc_pkg;
  // Write pulse timing register layout
  localparam logic [7:0] ISBC_WPT_RESET = 8'h7B;
  localparam logic [7:0] ISBC_WPT_RW_MASK = 8'h7F;
  localparam int ISBC_WPT_RO_BIT = 7;
  // Unlock register key in bits 7..2
  localparam logic [5:0] ISBC_KEY_VALUE = 6'h26;
  localparam int ISBC_KEY_LSB = 2;
  // Unlock window length in instruction cycles
  localparam int ISBC_KEY_CYCLES = 8;
  localparam logic [3:0] ISBC_KEY_CNT_LOAD = 4'h8;
  // Force-boot pin hold after reset release
  localparam int ISBC_HV_HOLD_CYCLES = 3;
  // Debounce length for force-boot pin going low
  localparam logic [3:0] ISBC_DEBOUNCE_CNT = 4'h4;
  // Execution start addresses
  localparam logic [15:0] ISBC_START_ADDR = 16'h0000;
  // Pulse width scale: cycles per timing code step
  localparam logic [3:0] ISBC_PULSE_SCALE = 4'h4;
  // Execution source
  typedef enum logic [0:0] {
    ISBC_SRC_FLASH = 1'b0,
    ISBC_SRC_BOOT = 1'b1
  } isbc_src_t;
  // Flash pulse sequencer states
  typedef enum logic [1:0] {
    ISBC_P_IDLE = 2'b00,
    ISBC_P_PULSE = 2'b01,
    ISBC_P_DONE = 2'b10
  } isbc_pst_t;
endpackage

// [rtl/isbc_boot_entry.sv]
`timescale 1ns/100ps
// Overview of operation
// - Flash pulse width derives from timing register
// - Reset loads timing code 01111011
// - Timing bit 7 read-only, rest writable
// - Boot routine refuses flash until timing defined
// - Jump-to-boot enters boot only when unlocked
// - Unlock set only by key 100110
// - Unlock flag lasts exactly 8 cycles
// - Breakpoint in emulation freezes unlock counter
// - Counter keeps running during interrupt service
// - Return-to-flash goes back to flash
// - Forced boot ignores option bit, starts boot 0000
// - Later normal reset honours unerased option bit
// - Forced boot never alters option or security
// - Security clears only by mass erase, except user
// - High voltage outputs load clock, pin reads 1
// - Boot waits for debounced pin low
// - Option bit 0 boots from boot ROM
// - Option bit 1 starts flash 0000
module isbc_boot_entry
  import isbc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Timing register access
  input wire logic wpt_wr,
  input wire logic [7:0] wpt_wdata,
  output logic [7:0] wpt_rdata,
  // Unlock register write
  input wire logic key_wr,
  input wire logic [7:0] key_wdata,
  output logic unlock_flag,
  // Instruction decode strobes
  input wire logic jump_to_boot_instr,
  input wire logic return_to_flash_instr,
  input wire logic [15:0] jump_target,
  output logic exec_from_boot,
  output logic jump_taken,
  output logic [15:0] jump_addr,
  // Emulation breakpoint
  input wire logic emul_mode,
  input wire logic breakpoint,
  // Option bits and flash requests
  input wire logic boot_source_opt,
  input wire logic security_bit,
  input wire logic mass_erase_req,
  input wire logic user_isp_clear,
  input wire logic flash_op_req,
  output logic flash_pulse,
  output logic flash_op_refused,
  output logic security_q_out,
  // Force-boot pin and load clock
  input wire logic force_boot_hv,
  input wire logic force_boot_pin_in,
  input wire logic load_clock,
  output logic force_boot_pin_read,
  output logic load_clock_pin_out,
  output logic load_clock_pin_oe,
  output logic isp_enable
);

  // All block state
  typedef struct packed {
    logic [7:0] wpt;
    logic wpt_defined;
    logic [3:0] key_cnt;
    isbc_src_t src;
    logic forced;
    logic in_reset;
    logic [3:0] deb_cnt;
    logic isp_en;
    logic security;
    isbc_pst_t pst;
    logic [11:0] pcnt;
    logic jtaken;
    logic [15:0] jaddr;
    logic refused;
  } isbc_state_t;

  isbc_state_t s_q;
  isbc_state_t s_d;
  logic key_match;
  logic pin_level;

  // Key compare on upper six bits, low two ignored
  assign key_match = key_wdata[7:ISBC_KEY_LSB] == ISBC_KEY_VALUE;
  // High voltage reads as logic 1
  assign pin_level = force_boot_hv | force_boot_pin_in;

  // Next-state logic
  always_comb
  begin
    s_d = s_q;
    s_d.jtaken = 1'b0;
    s_d.refused = 1'b0;
    // Register write: bit 7 kept
    if (wpt_wr)
    begin
      s_d.wpt = (s_q.wpt & ~ISBC_WPT_RW_MASK) | (wpt_wdata & ISBC_WPT_RW_MASK);
      s_d.wpt_defined = 1'b1;
    end
    // Unlock counter; frozen on emulation breakpoint, not on interrupts
    if (key_wr && key_match)
      s_d.key_cnt = ISBC_KEY_CNT_LOAD;
    else if (s_q.key_cnt != 4'h0 && !(emul_mode && breakpoint))
      s_d.key_cnt = s_q.key_cnt - 4'h1;
    // Jump to boot only while unlocked
    if (jump_to_boot_instr)
    begin
      s_d.jtaken = 1'b1;
      if (s_q.key_cnt != 4'h0)
      begin
        s_d.src = ISBC_SRC_BOOT;
        s_d.jaddr = jump_target;
      end
      else
      begin
        s_d.src = ISBC_SRC_FLASH;
        s_d.jaddr = jump_target;
      end
    end
    else if (return_to_flash_instr)
    begin
      s_d.src = ISBC_SRC_FLASH;
      s_d.jtaken = 1'b1;
      s_d.jaddr = jump_target;
    end
    // Coming out of reset: pick start source
    if (s_q.in_reset)
    begin
      s_d.in_reset = 1'b0;
      s_d.jaddr = ISBC_START_ADDR;
      s_d.forced = force_boot_hv;
      if (force_boot_hv)
        s_d.src = ISBC_SRC_BOOT;
      else if (boot_source_opt)
        s_d.src = ISBC_SRC_FLASH;
      else
        s_d.src = ISBC_SRC_BOOT;
    end
    // Debounce pin low before enabling serial routine
    if (s_q.forced && !s_q.isp_en)
    begin
      if (pin_level)
        s_d.deb_cnt = ISBC_DEBOUNCE_CNT;
      else if (s_q.deb_cnt != 4'h0)
        s_d.deb_cnt = s_q.deb_cnt - 4'h1;
      else
        s_d.isp_en = 1'b1;
    end
    // Security clears only by mass erase or user routine; untouched by force
    if (mass_erase_req || user_isp_clear)
      s_d.security = 1'b0;
    // Option copy on the first cycle out of reset; the load wins over a clear
    if (s_q.in_reset)
      s_d.security = security_bit;
    // Flash pulse sequencer
    case (s_q.pst)
      ISBC_P_IDLE:
      begin
        if (flash_op_req)
        begin
          if (!s_q.wpt_defined && s_q.src == ISBC_SRC_BOOT)
            s_d.refused = 1'b1;
          else
          begin
            s_d.pst = ISBC_P_PULSE;
            s_d.pcnt = 12'({s_q.wpt[6:0], 2'b00});
          end
        end
      end
      ISBC_P_PULSE:
      begin
        if (s_q.pcnt == 12'h000)
          s_d.pst = ISBC_P_DONE;
        else
          s_d.pcnt = s_q.pcnt - 12'h001;
      end
      default:
        s_d.pst = ISBC_P_IDLE;
    endcase
  end

  // State register; reset acts even while the clock enable is low
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.wpt <= ISBC_WPT_RESET;
      s_q.in_reset <= 1'b1;
      s_q.security <= 1'b1;
      s_q.deb_cnt <= ISBC_DEBOUNCE_CNT;
      s_q.key_cnt <= 4'h0;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign wpt_rdata = s_q.wpt;
  assign unlock_flag = s_q.key_cnt != 4'h0;
  assign exec_from_boot = s_q.src == ISBC_SRC_BOOT;
  assign jump_taken = s_q.jtaken;
  assign jump_addr = s_q.jaddr;
  assign flash_pulse = s_q.pst == ISBC_P_PULSE;
  assign flash_op_refused = s_q.refused;
  assign security_q_out = s_q.security;
  assign force_boot_pin_read = pin_level;
  assign load_clock_pin_out = force_boot_hv & load_clock;
  assign load_clock_pin_oe = force_boot_hv;
  assign isp_enable = s_q.isp_en;

  // Checks
  property p_key_sets;
    @(posedge clock) disable iff (sys_rst)
    clk_en && key_wr && key_match |=> unlock_flag;
  endproperty
  a_key_sets: assert property (p_key_sets) else $error("unlock not set");
  property p_key_len;
    @(posedge clock) disable iff (sys_rst)
    clk_en && key_wr && key_match ##1 (clk_en && !key_wr && !(emul_mode && breakpoint))[*8] |=> !unlock_flag;
  endproperty
  a_key_len: assert property (p_key_len) else $error("unlock window wrong");
  property p_bad_key;
    @(posedge clock) disable iff (sys_rst)
    clk_en && key_wr && !key_match && !unlock_flag |=> !unlock_flag;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key unlocked");
  property p_freeze;
    @(posedge clock) disable iff (sys_rst)
    clk_en && emul_mode && breakpoint && !key_wr && unlock_flag |=> $stable(s_q.key_cnt);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter not frozen");
  property p_jump;
    @(posedge clock) disable iff (sys_rst)
    clk_en && !s_q.in_reset && jump_to_boot_instr |=> exec_from_boot == $past(unlock_flag);
  endproperty
  a_jump: assert property (p_jump) else $error("jump source wrong");
  property p_ret;
    @(posedge clock) disable iff (sys_rst)
    clk_en && !s_q.in_reset && return_to_flash_instr && !jump_to_boot_instr |=> !exec_from_boot;
  endproperty
  a_ret: assert property (p_ret) else $error("return failed");
  property p_force;
    @(posedge clock) disable iff (sys_rst)
    clk_en && s_q.in_reset && force_boot_hv |=> exec_from_boot && jump_addr == ISBC_START_ADDR;
  endproperty
  a_force: assert property (p_force) else $error("forced boot missed");
  property p_opt;
    @(posedge clock) disable iff (sys_rst)
    clk_en && s_q.in_reset && !force_boot_hv |=> exec_from_boot == !$past(boot_source_opt);
  endproperty
  a_opt: assert property (p_opt) else $error("option boot wrong");
  property p_rst;
    @(posedge clock) sys_rst |=> !unlock_flag && wpt_rdata == ISBC_WPT_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_ro7;
    @(posedge clock) disable iff (sys_rst)
    clk_en && wpt_wr |=> wpt_rdata[ISBC_WPT_RO_BIT] == $past(wpt_rdata[ISBC_WPT_RO_BIT]);
  endproperty
  a_ro7: assert property (p_ro7) else $error("bit 7 written");
  property p_pulse_start;
    @(posedge clock) disable iff (sys_rst)
    clk_en && s_q.pst == ISBC_P_IDLE && flash_op_req && (s_q.wpt_defined || !exec_from_boot)
      |=> flash_pulse && s_q.pcnt == 12'($past(wpt_rdata[6:0])) * 12'(ISBC_PULSE_SCALE);
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse width load wrong");
  property p_refuse;
    @(posedge clock) disable iff (sys_rst)
    clk_en && s_q.pst == ISBC_P_IDLE && flash_op_req && !s_q.wpt_defined && exec_from_boot |=> flash_op_refused && !flash_pulse;
  endproperty
  a_refuse: assert property (p_refuse) else $error("undefined timing not refused");
  property p_isp_en;
    @(posedge clock) disable iff (sys_rst)
    clk_en && !isp_enable && pin_level |=> !isp_enable;
  endproperty
  a_isp_en: assert property (p_isp_en) else $error("serial routine enabled while pin high");
  property p_sec_clear;
    @(posedge clock) disable iff (sys_rst)
    clk_en && !s_q.in_reset && (mass_erase_req || user_isp_clear) |=> !security_q_out;
  endproperty
  a_sec_clear: assert property (p_sec_clear) else $error("security not cleared");
  property p_sec_hold;
    @(posedge clock) disable iff (sys_rst)
    clk_en && !s_q.in_reset && !mass_erase_req && !user_isp_clear |=> $stable(security_q_out);
  endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("security changed without erase");
  property p_xfer;
    @(posedge clock) disable iff (sys_rst)
    clk_en && !s_q.in_reset && (jump_to_boot_instr || return_to_flash_instr) |=> jump_taken && jump_addr == $past(jump_target);
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer address wrong");
  c_unlock_jump: cover property (@(posedge clock) unlock_flag && jump_to_boot_instr);
  c_forced: cover property (@(posedge clock) isp_enable);
  c_pulse: cover property (@(posedge clock) flash_pulse);
  c_refuse: cover property (@(posedge clock) flash_op_refused);
endmodule

// [testbench/isbc_prog_model.sv]
`timescale 1ns/100ps
// External programmer: owns reset and the high-voltage boot pin
module isbc_prog_model
(
  // Clock
  input wire logic clock,
  // Pins driven by the programmer
  output logic sys_rst,
  output logic force_boot_hv,
  output logic force_boot_pin_in
);
  // Reset held from time zero
  initial
  begin
    sys_rst = 1'b1;
    force_boot_hv = 1'b0;
    force_boot_pin_in = 1'b0;
  end
  // High voltage only once reset is already held
  task automatic do_reset(input logic hv, input int len);
    // Reset already held from time zero: spend no extra edge
    if (!sys_rst)
    begin
      @(posedge clock);
      #1 sys_rst = 1'b1;
    end
    @(posedge clock);
    #1 force_boot_hv = hv;
    force_boot_pin_in = hv;
    repeat (len - 1) @(posedge clock);
    #1 sys_rst = 1'b0;
  endtask
  // Voltage kept well past three cycles after release
  task automatic drop_hv;
    repeat (4) @(posedge clock);
    #1 force_boot_hv = 1'b0;
    force_boot_pin_in = 1'b0;
  endtask
endmodule

// [testbench/test_isbc_boot_entry.sv]
`timescale 1ns/100ps
module test_isbc_boot_entry import isbc_pkg::*;;
  // Bench-driven inputs
  logic clock = 1'b0;
  logic sys_rst, force_boot_hv, force_boot_pin_in;
  logic wpt_wr = 1'b0, key_wr = 1'b0, jump_to_boot_instr = 1'b0, return_to_flash_instr = 1'b0;
  logic emul_mode = 1'b0, breakpoint = 1'b0, boot_source_opt = 1'b1, flash_op_req = 1'b0, load_clock = 1'b0;
  logic [7:0] wpt_wdata = 8'h00, key_wdata = 8'h00;
  logic [15:0] jump_target = 16'h1234;
  logic clk_en = 1'b1, security_bit = 1'b1, mass_erase_req = 1'b0, user_isp_clear = 1'b0;
  // Design outputs
  logic [7:0] wpt_rdata;
  logic [15:0] jump_addr;
  logic unlock_flag, exec_from_boot, jump_taken, flash_pulse, flash_op_refused, security_q_out;
  logic force_boot_pin_read, load_clock_pin_out, load_clock_pin_oe, isp_enable;
  int bad_count = 0, checks = 0, n;
  // 20 MHz clock
  initial
  begin
    forever #25 clock = ~clock;
  end
  // Load clock runs at half rate so its copy on the pin is visible
  always @(posedge clock) load_clock <= ~load_clock;
  isbc_prog_model prog (.clock, .sys_rst, .force_boot_hv, .force_boot_pin_in);
  // Every input comes from the bench so enable, security and erase paths are exercised
  isbc_boot_entry uut (.clock, .sys_rst, .clk_en, .wpt_wr, .wpt_wdata, .wpt_rdata, .key_wr, .key_wdata,
    .unlock_flag, .jump_to_boot_instr, .return_to_flash_instr, .jump_target, .exec_from_boot, .jump_taken,
    .jump_addr, .emul_mode, .breakpoint, .boot_source_opt, .security_bit, .mass_erase_req,
    .user_isp_clear, .flash_op_req, .flash_pulse, .flash_op_refused, .security_q_out, .force_boot_hv,
    .force_boot_pin_in, .load_clock, .force_boot_pin_read, .load_clock_pin_out, .load_clock_pin_oe, .isp_enable);
  // Step k edges, then settle
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // Value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle write to timing or unlock register
  task automatic wr(input logic is_key, input logic [7:0] d);
    key_wr = is_key;
    wpt_wr = !is_key;
    key_wdata = d;
    wpt_wdata = d;
    cyc(1);
    key_wr = 1'b0;
    wpt_wr = 1'b0;
  endtask
  // Count high cycles of a selected output over k cycles
  task automatic cnt(input int s, input int k);
    n = 0;
    repeat (k)
    begin
      if ((s == 0 ? unlock_flag : s == 1 ? flash_pulse : flash_op_refused) === 1'b1) n++;
      cyc(1);
    end
  endtask
  // Verdict and stop
  task automatic end_sim;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial
  begin
    #150000;
    bad_count++;
    end_sim;
  end
  // Test sequence
  initial
  begin
    prog.do_reset(1'b0, 6);
    cyc(2);
    chk(16'(wpt_rdata), 16'(ISBC_WPT_RESET));
    chk(16'(exec_from_boot), 16'h0000);
    wr(1'b0, 8'hFF);
    cyc(1);
    chk(16'(wpt_rdata), 16'h007F);
    wr(1'b0, 8'h01);
    chk(16'(wpt_rdata), 16'h0001);
    flash_op_req = 1'b1;
    cyc(1);
    flash_op_req = 1'b0;
    cnt(1, 20);
    chk(n[15:0], 16'h0005);
    $display("timing test done");
    wr(1'b1, 8'h9C);
    cnt(0, 12);
    chk(n[15:0], 16'h0000);
    wr(1'b1, 8'h9B);
    cnt(0, 12);
    chk(n[15:0], 16'h0008);
    jump_to_boot_instr = 1'b1;
    cyc(1);
    jump_to_boot_instr = 1'b0;
    chk(jump_addr, jump_target);
    chk(16'(jump_taken), 16'h0001);
    chk(16'(exec_from_boot), 16'h0000);
    wr(1'b1, 8'h98);
    chk(16'(jump_taken), 16'h0000);
    jump_to_boot_instr = 1'b1;
    cyc(1);
    jump_to_boot_instr = 1'b0;
    chk(16'(exec_from_boot), 16'h0001);
    return_to_flash_instr = 1'b1;
    cyc(1);
    return_to_flash_instr = 1'b0;
    chk(16'(exec_from_boot), 16'h0000);
    chk(16'(jump_taken), 16'h0001);
    // Interrupts are outside this block; nothing to mask
    emul_mode = 1'b1;
    wr(1'b1, 8'h98);
    cyc(2);
    breakpoint = 1'b1;
    cyc(7);
    breakpoint = 1'b0;
    chk(16'(unlock_flag), 16'h0001);
    cnt(0, 12);
    chk(n[15:0], 16'h0006);
    // Window counts enabled cycles only: four frozen cycles do not shorten it
    emul_mode = 1'b0;
    wr(1'b1, 8'h98);
    clk_en = 1'b0;
    cyc(4);
    clk_en = 1'b1;
    cnt(0, 12);
    chk(n[15:0], 16'h0008);
    $display("unlock test done");
    wr(1'b1, 8'h98);
    prog.do_reset(1'b1, 6);
    chk(16'(unlock_flag), 16'h0000);
    cyc(2);
    chk(16'(exec_from_boot), 16'h0001);
    chk(jump_addr, ISBC_START_ADDR);
    chk(16'(force_boot_pin_read), 16'h0001);
    chk(16'(load_clock_pin_oe), 16'h0001);
    chk(16'(load_clock_pin_out), 16'(load_clock));
    chk(16'(security_q_out), 16'h0001);
    flash_op_req = 1'b1;
    cyc(1);
    flash_op_req = 1'b0;
    cnt(2, 3);
    chk(n[15:0], 16'h0001);
    chk(16'(isp_enable), 16'h0000);
    prog.drop_hv();
    n = 0;
    while (isp_enable !== 1'b1 && n < 30)
    begin
      cyc(1);
      n++;
    end
    chk(16'(isp_enable), 16'h0001);
    chk(n[15:0], 16'(ISBC_DEBOUNCE_CNT) + 16'h0001);
    chk(16'(load_clock_pin_oe), 16'h0000);
    mass_erase_req = 1'b1;
    cyc(1);
    mass_erase_req = 1'b0;
    chk(16'(security_q_out), 16'h0000);
    $display("forced boot test done");
    prog.do_reset(1'b0, 6);
    cyc(2);
    chk(16'(exec_from_boot), 16'h0000);
    chk(16'(security_q_out), 16'h0001);
    user_isp_clear = 1'b1;
    cyc(1);
    user_isp_clear = 1'b0;
    chk(16'(security_q_out), 16'h0000);
    boot_source_opt = 1'b0;
    security_bit = 1'b0;
    prog.do_reset(1'b0, 6);
    cyc(2);
    chk(16'(exec_from_boot), 16'h0001);
    chk(16'(security_q_out), 16'h0000);
    $display("option bit test done");
    end_sim;
  end
endmodule
